// *** hw/timer16_ctrl_status.sv ***
// What this block does
// - capture flags interrupt when capture enable set
// - compare flags interrupt when compare enable set
// - overflow flag interrupts when overflow enable set
// - all sources merged into one request
// - force bit drives level onto enabled pin
// - level two to pin two, pin one in modes
// - compare one match copies level one out
// - capture pin one edge: 0 falling 1 rising
// - capture pin two edge: 0 falling 1 rising
// - pin enables only route, compares keep running
// - single pulse triggered by capture pin one
// - pwm: width compare one, period compare two
// - clock select: div4, div2, div8, external
// - external select without pin stops counter
// - external clock edge: 0 falling 1 rising
// - capture flag one set, cleared status-then-low
// - compare flag one set, cleared status-then-low
// - overflow flag; alternate low byte never clears
// - capture flag two set, cleared status-then-low
// - compare flag two set, cleared status-then-low
// - disable freezes counting and releases both pins
// - no compare flags in pwm mode
// - pwm compare two reloads counter to fffc
`timescale 1ns/1ps
`default_nettype none
module timer16_ctrl_status #(
   parameter bit HAS_EXT_CLOCK = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic capture_pin_one,
   input wire logic capture_pin_two,
   input wire logic ext_clock_pin,
   output logic compare_pin_one,
   output logic compare_pin_one_oe,
   output logic compare_pin_two,
   output logic compare_pin_two_oe,
   output logic timer_irq
);
   logic [7:0] timer_control_one;
   logic [7:0] timer_control_two;
   logic timer_disable;
   logic capture_flag_one, capture_flag_two, compare_flag_one, compare_flag_two, overflow_flag;
   logic [15:0] count, cap_one, cap_two, compare_value_one, compare_value_two;
   logic [15:0] pwm_one, pwm_two;
   logic [7:0] cmp_one_high_hold, cmp_two_high_hold;
   logic cmp_one_armed, cmp_two_armed;
   logic [2:0] presc;
   logic level_one, level_two, status_seen;
   logic [7:0] next_ctrl_one, next_ctrl_two;
   logic next_disable;
   logic next_cf1, next_cf2, next_of1, next_of2, next_ovf;
   logic [15:0] next_count, next_cap_one, next_cap_two, next_cv1, next_cv2;
   logic [15:0] next_pwm_one, next_pwm_two;
   logic [7:0] next_h1, next_h2;
   logic next_arm1, next_arm2;
   logic [2:0] next_presc;
   logic next_level_one, next_level_two, next_seen;
   logic [31:0] next_prdata;
   logic next_ready;
   logic next_pin1, next_pin1_oe, next_pin2, next_pin2_oe, next_irq;
   logic cap1_edge, cap2_edge, ext_edge;
   logic setup, acc, wr, rd;
   logic pwm_mode, pulse_mode, tick, match1, match2;

   edge_detect cap_one_det (.pclk(pclk), .presetn(presetn), .pin(capture_pin_one),
      .rising(timer_control_one[timer16_pkg::EDGE_ONE]), .hit(cap1_edge));
   edge_detect cap_two_det (.pclk(pclk), .presetn(presetn), .pin(capture_pin_two),
      .rising(timer_control_two[timer16_pkg::EDGE_TWO]), .hit(cap2_edge));
   edge_detect ext_det (.pclk(pclk), .presetn(presetn), .pin(ext_clock_pin),
      .rising(timer_control_two[timer16_pkg::EXT_EDGE]), .hit(ext_edge));

   always_comb begin
      // the apb answer comes one cycle after setup; the access is taken on that edge
      setup = psel & ~penable;
      acc = psel & penable & pready;
      wr = acc & pwrite;
      rd = acc & ~pwrite;
      pwm_mode = timer_control_two[timer16_pkg::PWM_EN];
      pulse_mode = timer_control_two[timer16_pkg::PULSE_EN] & ~pwm_mode;
      next_presc = presc;
      tick = 1'b0;
      if (!timer_disable) begin
         next_presc = presc + 3'h1;
         case (timer_control_two[timer16_pkg::CLK_SEL_HI:timer16_pkg::CLK_SEL_LO])
            timer16_pkg::CLK_DIV4: tick = (presc[1:0] == 2'h3);
            timer16_pkg::CLK_DIV2: tick = presc[0];
            timer16_pkg::CLK_DIV8: tick = (presc == 3'h7);
            timer16_pkg::CLK_EXT: tick = HAS_EXT_CLOCK & ext_edge;
            default: tick = 1'b0;
         endcase
      end
      // pwm uses the double-buffered copies, taken at the period end
      match1 = (count == (pwm_mode ? pwm_one : compare_value_one)) & cmp_one_armed;
      match2 = (count == (pwm_mode ? pwm_two : compare_value_two)) & cmp_two_armed;
      next_count = count;
      next_pwm_one = pwm_one;
      next_pwm_two = pwm_two;
      // outside pwm the copies follow the compare values, so pwm starts on fresh ones
      if (!pwm_mode) begin
         next_pwm_one = compare_value_one;
         next_pwm_two = compare_value_two;
      end
      if (tick) begin
         next_count = count + 16'h0001;
      end
      if (pwm_mode && match2 && tick) begin
         next_count = timer16_pkg::COUNT_RESET;
         next_pwm_one = compare_value_one;
         next_pwm_two = compare_value_two;
      end
      if (pulse_mode && cap1_edge && !timer_disable) begin
         next_count = timer16_pkg::COUNT_RESET;
      end
      if (wr && (paddr == timer16_pkg::CNT_LOW_ADDR || paddr == timer16_pkg::ALT_LOW_ADDR)) begin
         next_count = timer16_pkg::COUNT_RESET;
      end
      // register writes
      next_ctrl_one = timer_control_one;
      next_ctrl_two = timer_control_two;
      next_disable = timer_disable;
      next_cv1 = compare_value_one;
      next_cv2 = compare_value_two;
      next_h1 = cmp_one_high_hold;
      next_h2 = cmp_two_high_hold;
      next_arm1 = cmp_one_armed;
      next_arm2 = cmp_two_armed;
      if (wr) begin
         case (paddr)
            timer16_pkg::CTRL_ONE_ADDR: next_ctrl_one = pwdata[7:0];
            timer16_pkg::CTRL_TWO_ADDR: next_ctrl_two = pwdata[7:0];
            timer16_pkg::STATUS_ADDR: next_disable = pwdata[timer16_pkg::DISABLE_BIT];
            timer16_pkg::CMP_ONE_HIGH_ADDR: begin
               next_h1 = pwdata[7:0];
               next_arm1 = 1'b0;
            end
            timer16_pkg::CMP_ONE_LOW_ADDR: begin
               next_cv1 = {cmp_one_high_hold, pwdata[7:0]};
               next_arm1 = 1'b1;
            end
            timer16_pkg::CMP_TWO_HIGH_ADDR: begin
               next_h2 = pwdata[7:0];
               next_arm2 = 1'b0;
            end
            timer16_pkg::CMP_TWO_LOW_ADDR: begin
               next_cv2 = {cmp_two_high_hold, pwdata[7:0]};
               next_arm2 = 1'b1;
            end
            default: next_disable = timer_disable;
         endcase
      end
      // flags: set wins over the status-then-low-byte clear
      next_seen = status_seen;
      if (acc) begin
         next_seen = rd && (paddr == timer16_pkg::STATUS_ADDR);
      end
      next_cf1 = capture_flag_one;
      next_cf2 = capture_flag_two;
      next_of1 = compare_flag_one;
      next_of2 = compare_flag_two;
      next_ovf = overflow_flag;
      if (acc && status_seen) begin
         if (paddr == timer16_pkg::CAP_ONE_LOW_ADDR) next_cf1 = 1'b0;
         if (paddr == timer16_pkg::CMP_ONE_LOW_ADDR) next_of1 = 1'b0;
         if (paddr == timer16_pkg::CNT_LOW_ADDR) next_ovf = 1'b0;
         if (paddr == timer16_pkg::CAP_TWO_LOW_ADDR) next_cf2 = 1'b0;
         if (paddr == timer16_pkg::CMP_TWO_LOW_ADDR) next_of2 = 1'b0;
      end
      next_cap_one = cap_one;
      next_cap_two = cap_two;
      // capture pin one is disconnected from capture in pwm mode
      if (cap1_edge && !pwm_mode) begin
         next_cf1 = 1'b1;
         next_cap_one = count;
      end
      if (pwm_mode && match2 && tick) next_cf1 = 1'b1;
      if (cap2_edge) begin
         next_cf2 = 1'b1;
         next_cap_two = count;
      end
      // compares run whatever the pin enables say; none in pwm, one not in pulse
      if (match1 && tick && !pwm_mode && !pulse_mode) next_of1 = 1'b1;
      if (match2 && tick && !pwm_mode) next_of2 = 1'b1;
      if (tick && count == timer16_pkg::COUNT_ALL_ONES) next_ovf = 1'b1;
      // output levels
      next_level_one = level_one;
      next_level_two = level_two;
      if (pwm_mode || pulse_mode) begin
         if ((pulse_mode && cap1_edge) || (pwm_mode && match2 && tick)) begin
            next_level_one = timer_control_one[timer16_pkg::LEVEL_TWO];
         end else if (match1 && tick) begin
            next_level_one = timer_control_one[timer16_pkg::LEVEL_ONE];
         end
      end else begin
         if (match1 && tick) next_level_one = timer_control_one[timer16_pkg::LEVEL_ONE];
         if (match2 && tick) next_level_two = timer_control_one[timer16_pkg::LEVEL_TWO];
      end
      if (timer_control_one[timer16_pkg::FORCE_ONE]) begin
         next_level_one = timer_control_one[timer16_pkg::LEVEL_ONE];
      end
      if (timer_control_one[timer16_pkg::FORCE_TWO]) begin
         next_level_two = timer_control_one[timer16_pkg::LEVEL_TWO];
      end
      next_pin1 = next_level_one;
      next_pin2 = next_level_two;
      next_pin1_oe = timer_control_two[timer16_pkg::PIN_ONE_EN] & ~timer_disable;
      next_pin2_oe = timer_control_two[timer16_pkg::PIN_TWO_EN] & ~timer_disable;
      next_irq = (timer_control_one[timer16_pkg::CAP_IE] & (capture_flag_one | capture_flag_two))
         | (timer_control_one[timer16_pkg::CMP_IE] & (compare_flag_one | compare_flag_two))
         | (timer_control_one[timer16_pkg::OVF_IE] & overflow_flag);
      next_ready = setup;
      next_prdata = 32'h0000_0000;
      if (setup && !pwrite) begin
         case (paddr)
            timer16_pkg::CTRL_ONE_ADDR: next_prdata[7:0] = timer_control_one;
            timer16_pkg::CTRL_TWO_ADDR: next_prdata[7:0] = timer_control_two;
            // reserved low bits read zero, software keeps them zero
            timer16_pkg::STATUS_ADDR: next_prdata[7:0] = {capture_flag_one, compare_flag_one,
               overflow_flag, capture_flag_two, compare_flag_two, timer_disable, 2'h0};
            timer16_pkg::CAP_ONE_HIGH_ADDR: next_prdata[7:0] = cap_one[15:8];
            timer16_pkg::CAP_ONE_LOW_ADDR: next_prdata[7:0] = cap_one[7:0];
            timer16_pkg::CMP_ONE_HIGH_ADDR: next_prdata[7:0] = compare_value_one[15:8];
            timer16_pkg::CMP_ONE_LOW_ADDR: next_prdata[7:0] = compare_value_one[7:0];
            timer16_pkg::CMP_TWO_HIGH_ADDR: next_prdata[7:0] = compare_value_two[15:8];
            timer16_pkg::CMP_TWO_LOW_ADDR: next_prdata[7:0] = compare_value_two[7:0];
            timer16_pkg::CNT_HIGH_ADDR: next_prdata[7:0] = count[15:8];
            timer16_pkg::CNT_LOW_ADDR: next_prdata[7:0] = count[7:0];
            timer16_pkg::ALT_HIGH_ADDR: next_prdata[7:0] = count[15:8];
            timer16_pkg::ALT_LOW_ADDR: next_prdata[7:0] = count[7:0];
            timer16_pkg::CAP_TWO_HIGH_ADDR: next_prdata[7:0] = cap_two[15:8];
            timer16_pkg::CAP_TWO_LOW_ADDR: next_prdata[7:0] = cap_two[7:0];
            default: next_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_control_one <= timer16_pkg::CTRL_RESET;
         timer_control_two <= timer16_pkg::CTRL_RESET;
         timer_disable <= 1'b0;
         capture_flag_one <= 1'b0;
         capture_flag_two <= 1'b0;
         compare_flag_one <= 1'b0;
         compare_flag_two <= 1'b0;
         overflow_flag <= 1'b0;
         count <= timer16_pkg::COUNT_RESET;
         cap_one <= 16'h0000;
         cap_two <= 16'h0000;
         compare_value_one <= timer16_pkg::CMP_RESET;
         compare_value_two <= timer16_pkg::CMP_RESET;
         pwm_one <= timer16_pkg::CMP_RESET;
         pwm_two <= timer16_pkg::CMP_RESET;
         cmp_one_high_hold <= 8'h80;
         cmp_two_high_hold <= 8'h80;
         cmp_one_armed <= 1'b1;
         cmp_two_armed <= 1'b1;
         presc <= 3'h0;
         level_one <= 1'b0;
         level_two <= 1'b0;
         status_seen <= 1'b0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         compare_pin_one <= 1'b0;
         compare_pin_one_oe <= 1'b0;
         compare_pin_two <= 1'b0;
         compare_pin_two_oe <= 1'b0;
         timer_irq <= 1'b0;
      end else begin
         timer_control_one <= next_ctrl_one;
         timer_control_two <= next_ctrl_two;
         timer_disable <= next_disable;
         capture_flag_one <= next_cf1;
         capture_flag_two <= next_cf2;
         compare_flag_one <= next_of1;
         compare_flag_two <= next_of2;
         overflow_flag <= next_ovf;
         count <= next_count;
         cap_one <= next_cap_one;
         cap_two <= next_cap_two;
         compare_value_one <= next_cv1;
         compare_value_two <= next_cv2;
         pwm_one <= next_pwm_one;
         pwm_two <= next_pwm_two;
         cmp_one_high_hold <= next_h1;
         cmp_two_high_hold <= next_h2;
         cmp_one_armed <= next_arm1;
         cmp_two_armed <= next_arm2;
         presc <= next_presc;
         level_one <= next_level_one;
         level_two <= next_level_two;
         status_seen <= next_seen;
         prdata <= next_prdata;
         pready <= next_ready;
         compare_pin_one <= next_pin1;
         compare_pin_one_oe <= next_pin1_oe;
         compare_pin_two <= next_pin2;
         compare_pin_two_oe <= next_pin2_oe;
         timer_irq <= next_irq;
      end
   end

   assign pslverr = 1'b0;

   overflow_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
      (overflow_flag && timer_control_one[5]) |=> timer_irq)
      else $error("overflow flag enabled but no interrupt");
   no_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
      (timer_control_one[7:5] == 3'h0) |=> !timer_irq)
      else $error("interrupt with all enables clear");
   capture_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
      (capture_flag_two && timer_control_one[7]) |=> timer_irq)
      else $error("capture flag enabled but no interrupt");
   compare_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
      (compare_flag_one && timer_control_one[6]) |=> timer_irq)
      else $error("compare flag enabled but no interrupt");
   freeze_count_a: assert property (@(posedge pclk) disable iff (!presetn)
      (timer_disable && !(psel && penable)) |=> $stable(count))
      else $error("counter moved while disabled");
   pin_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      timer_disable |=> !compare_pin_one_oe && !compare_pin_two_oe)
      else $error("compare pin driven while disabled");
   pwm_no_cmp_a: assert property (@(posedge pclk) disable iff (!presetn)
      (pwm_mode && !compare_flag_one) |=> !compare_flag_one)
      else $error("compare flag set in pwm mode");
   pwm_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
      (pwm_mode && match2 && tick && !wr && !pulse_mode) |=> count == 16'hFFFC)
      else $error("pwm period end did not reload counter");
   force_one_a: assert property (@(posedge pclk) disable iff (!presetn)
      timer_control_one[3] |=> compare_pin_one == $past(timer_control_one[0]))
      else $error("forced level not on pin one");
   ovf_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && count == 16'hFFFF) |=> overflow_flag)
      else $error("rollover did not set overflow flag");
endmodule
`default_nettype wire

// *** hw/timer16_pkg.sv ***
package timer16_pkg;
   // register byte offsets on the apb bus (word aligned)
   localparam logic [7:0] CTRL_ONE_ADDR = 8'h00;
   localparam logic [7:0] CTRL_TWO_ADDR = 8'h04;
   localparam logic [7:0] STATUS_ADDR = 8'h08;
   localparam logic [7:0] CAP_ONE_HIGH_ADDR = 8'h0C;
   localparam logic [7:0] CAP_ONE_LOW_ADDR = 8'h10;
   localparam logic [7:0] CMP_ONE_HIGH_ADDR = 8'h14;
   localparam logic [7:0] CMP_ONE_LOW_ADDR = 8'h18;
   localparam logic [7:0] CMP_TWO_HIGH_ADDR = 8'h1C;
   localparam logic [7:0] CMP_TWO_LOW_ADDR = 8'h20;
   localparam logic [7:0] CNT_HIGH_ADDR = 8'h24;
   localparam logic [7:0] CNT_LOW_ADDR = 8'h28;
   localparam logic [7:0] ALT_HIGH_ADDR = 8'h2C;
   localparam logic [7:0] ALT_LOW_ADDR = 8'h30;
   localparam logic [7:0] CAP_TWO_HIGH_ADDR = 8'h34;
   localparam logic [7:0] CAP_TWO_LOW_ADDR = 8'h38;
   // control one fields
   localparam int CAP_IE = 7;
   localparam int CMP_IE = 6;
   localparam int OVF_IE = 5;
   localparam int FORCE_TWO = 4;
   localparam int FORCE_ONE = 3;
   localparam int LEVEL_TWO = 2;
   localparam int EDGE_ONE = 1;
   localparam int LEVEL_ONE = 0;
   // control two fields
   localparam int PIN_ONE_EN = 7;
   localparam int PIN_TWO_EN = 6;
   localparam int PULSE_EN = 5;
   localparam int PWM_EN = 4;
   localparam int CLK_SEL_HI = 3;
   localparam int CLK_SEL_LO = 2;
   localparam int EDGE_TWO = 1;
   localparam int EXT_EDGE = 0;
   // status fields
   localparam int DISABLE_BIT = 2;
   // clock select codes
   localparam logic [1:0] CLK_DIV4 = 2'h0;
   localparam logic [1:0] CLK_DIV2 = 2'h1;
   localparam logic [1:0] CLK_DIV8 = 2'h2;
   localparam logic [1:0] CLK_EXT = 2'h3;
   // reset and reload values
   localparam logic [15:0] COUNT_RESET = 16'hFFFC;
   localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
   localparam logic [15:0] CMP_RESET = 16'h8000;
   localparam logic [7:0] CTRL_RESET = 8'h00;
endpackage

// *** hw/edge_detect.sv ***
`timescale 1ns/1ps
`default_nettype none
// one-cycle pulse on the selected transition of a synchronous pin
module edge_detect (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   input wire logic rising,
   output logic hit
);
   logic last;
   logic primed;
   logic next_last;
   logic next_primed;
   always_comb begin
      next_last = pin;
      next_primed = 1'b1;
      // no edge in the first cycle out of reset, whatever level the pin idles at
      hit = primed & (rising ? (pin & ~last) : (~pin & last));
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last <= 1'b0;
         primed <= 1'b0;
      end else begin
         last <= next_last;
         primed <= next_primed;
      end
   end
endmodule
`default_nettype wire

// *** verification/timer16_pins_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// far side: capture sources and the external count clock
module timer16_pins_model (
   input wire logic pclk,
   output logic capture_pin_one,
   output logic capture_pin_two,
   output logic ext_clock_pin
);
   initial begin
      capture_pin_one = 1'b0;
      capture_pin_two = 1'b1;
      ext_clock_pin = 1'b0;
   end
   // level is held for hold cycles; short holds model a fast source, long ones a slow one
   task automatic drive(input int which, input logic level, input int hold);
      @(posedge pclk);
      case (which)
         0: capture_pin_one <= level;
         1: capture_pin_two <= level;
         default: ext_clock_pin <= level;
      endcase
      repeat (hold) @(posedge pclk);
   endtask
endmodule
`default_nettype wire

// *** verification/timer16_ctrl_status_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module timer16_ctrl_status_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, timer_irq, prev;
   logic [7:0] paddr, q, q0;
   logic [31:0] pwdata, prdata;
   logic capture_pin_one, capture_pin_two, ext_clock_pin;
   logic compare_pin_one, compare_pin_one_oe, compare_pin_two, compare_pin_two_oe;
   int err_count = 0;
   int samples_checked = 0;
   int n, toggles;

   timer16_ctrl_status #(.HAS_EXT_CLOCK(1'b1)) uut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .capture_pin_one(capture_pin_one), .capture_pin_two(capture_pin_two),
      .ext_clock_pin(ext_clock_pin), .compare_pin_one(compare_pin_one),
      .compare_pin_one_oe(compare_pin_one_oe), .compare_pin_two(compare_pin_two),
      .compare_pin_two_oe(compare_pin_two_oe), .timer_irq(timer_irq));
   timer16_pins_model pins (.pclk(pclk), .capture_pin_one(capture_pin_one),
      .capture_pin_two(capture_pin_two), .ext_clock_pin(ext_clock_pin));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge pclk);
   endtask
   // one idle edge first, so back-to-back calls never reassign psel in one step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int w;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      w = 0;
      do begin
         @(posedge pclk);
         w++;
      end while (pready !== 1'b1 && w < 50);
      q = prdata[7:0];
      if (w >= 50) chk("pready", 16'h0000, 16'h0001);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] m,
                         input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk(name, {8'h00, q & m}, {8'h00, e});
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge pclk);
      err_count++;
      final_report();
   end

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      presetn = 1'b0;
      cyc(8);
      presetn <= 1'b1;
      rd_chk("ctrl_one", timer16_pkg::CTRL_ONE_ADDR, 8'hFF, 8'h00);
      rd_chk("ctrl_two", timer16_pkg::CTRL_TWO_ADDR, 8'hFF, 8'h00);
      rd_chk("status", timer16_pkg::STATUS_ADDR, 8'h07, 8'h00);
      rd_chk("cmp_one_hi", timer16_pkg::CMP_ONE_HIGH_ADDR, 8'hFF, 8'h80);
      rd_chk("cmp_two_lo", timer16_pkg::CMP_TWO_LOW_ADDR, 8'hFF, 8'h00);
      rd_chk("unmapped", 8'hFC, 8'hFF, 8'h00);
      chk("pslverr", {15'h0000, pslverr}, 16'h0000);
      // overflow: flag alone, then enabled, write-proof, clear sequence
      cyc(100);
      rd_chk("tof_set", timer16_pkg::STATUS_ADDR, 8'h20, 8'h20);
      chk("irq_off", {15'h0000, timer_irq}, 16'h0000);
      apb(1'b1, timer16_pkg::CTRL_ONE_ADDR, 8'h20);
      cyc(3);
      chk("irq_ovf", {15'h0000, timer_irq}, 16'h0001);
      apb(1'b1, timer16_pkg::STATUS_ADDR, 8'h00);
      rd_chk("tof_kept", timer16_pkg::STATUS_ADDR, 8'h24, 8'h20);
      apb(1'b0, timer16_pkg::ALT_LOW_ADDR, 8'h00);
      rd_chk("tof_alt", timer16_pkg::STATUS_ADDR, 8'h20, 8'h20);
      apb(1'b0, timer16_pkg::CNT_LOW_ADDR, 8'h00);
      rd_chk("tof_clr", timer16_pkg::STATUS_ADDR, 8'h20, 8'h00);
      cyc(3);
      chk("irq_gone", {15'h0000, timer_irq}, 16'h0000);
      apb(1'b1, timer16_pkg::CTRL_ONE_ADDR, 8'h00);
      // prescaler codes, about 66 cycles from counter reset to sample
      for (int c = 0; c < 3; c++) begin
         apb(1'b1, timer16_pkg::CTRL_TWO_ADDR, 8'(c << 2));
         apb(1'b1, timer16_pkg::CNT_LOW_ADDR, 8'h00);
         cyc(64);
         apb(1'b0, timer16_pkg::CNT_LOW_ADDR, 8'h00);
         n = (c == 0) ? 16 : (c == 1) ? 33 : 8;
         q0 = q - 8'hFC;
         chk("ticks", (int'(q0) >= n - 2 && int'(q0) <= n + 2) ? 16'(n) : 16'(q0), 16'(n));
      end
      for (int e = 0; e < 2; e++) begin
         apb(1'b1, timer16_pkg::CTRL_TWO_ADDR, 8'(8'h0C | e));
         apb(1'b1, timer16_pkg::CNT_LOW_ADDR, 8'h00);
         pins.drive(2, 1'b1, 6);
         rd_chk("ext_rise", timer16_pkg::CNT_LOW_ADDR, 8'hFF, 8'(8'hFC + e));
         pins.drive(2, 1'b0, 6);
         rd_chk("ext_fall", timer16_pkg::CNT_LOW_ADDR, 8'hFF, 8'hFD);
      end
      // captures: one on falling edges, two on rising edges
      apb(1'b1, timer16_pkg::CTRL_ONE_ADDR, 8'h80);
      apb(1'b1, timer16_pkg::CTRL_TWO_ADDR, 8'h02);
      pins.drive(0, 1'b1, 6);
      rd_chk("cap1_wrong", timer16_pkg::STATUS_ADDR, 8'h80, 8'h00);
      chk("irq_cap_no", {15'h0000, timer_irq}, 16'h0000);
      pins.drive(0, 1'b0, 12);
      rd_chk("cap1_set", timer16_pkg::STATUS_ADDR, 8'h80, 8'h80);
      chk("irq_cap1", {15'h0000, timer_irq}, 16'h0001);
      apb(1'b0, timer16_pkg::CAP_ONE_LOW_ADDR, 8'h00);
      rd_chk("cap1_clr", timer16_pkg::STATUS_ADDR, 8'h80, 8'h00);
      pins.drive(1, 1'b0, 6);
      rd_chk("cap2_wrong", timer16_pkg::STATUS_ADDR, 8'h10, 8'h00);
      pins.drive(1, 1'b1, 6);
      rd_chk("cap2_set", timer16_pkg::STATUS_ADDR, 8'h10, 8'h10);
      chk("irq_cap2", {15'h0000, timer_irq}, 16'h0001);
      apb(1'b1, timer16_pkg::CAP_TWO_LOW_ADDR, 8'h00);
      rd_chk("cap2_clr", timer16_pkg::STATUS_ADDR, 8'h10, 8'h00);
      // compare matches at 0x0020 and 0x0030 on div2
      apb(1'b1, timer16_pkg::CTRL_ONE_ADDR, 8'h45);
      apb(1'b1, timer16_pkg::CTRL_TWO_ADDR, 8'hC4);
      apb(1'b1, timer16_pkg::CMP_ONE_HIGH_ADDR, 8'h00);
      apb(1'b1, timer16_pkg::CMP_ONE_LOW_ADDR, 8'h20);
      apb(1'b1, timer16_pkg::CMP_TWO_HIGH_ADDR, 8'h00);
      apb(1'b1, timer16_pkg::CMP_TWO_LOW_ADDR, 8'h30);
      apb(1'b1, timer16_pkg::CNT_LOW_ADDR, 8'h00);
      chk("pin1_idle", {14'h0000, compare_pin_one_oe, compare_pin_one}, 16'h0002);
      n = 0;
      while (compare_pin_two !== 1'b1 && n < 400) begin
         @(posedge pclk);
         n++;
      end
      chk("pins_match", {14'h0000, compare_pin_one, compare_pin_two}, 16'h0003);
      rd_chk("cmp_flags", timer16_pkg::STATUS_ADDR, 8'h48, 8'h48);
      chk("irq_cmp", {15'h0000, timer_irq}, 16'h0001);
      apb(1'b0, timer16_pkg::CMP_ONE_LOW_ADDR, 8'h00);
      apb(1'b0, timer16_pkg::STATUS_ADDR, 8'h00);
      apb(1'b1, timer16_pkg::CMP_TWO_LOW_ADDR, 8'h30);
      rd_chk("cmp_clr", timer16_pkg::STATUS_ADDR, 8'h48, 8'h00);
      // forced levels without any match
      apb(1'b1, timer16_pkg::CTRL_ONE_ADDR, 8'h18);
      cyc(3);
      chk("force_lo", {14'h0000, compare_pin_one, compare_pin_two}, 16'h0000);
      apb(1'b1, timer16_pkg::CTRL_ONE_ADDR, 8'h1D);
      cyc(3);
      chk("force_hi", {14'h0000, compare_pin_one, compare_pin_two}, 16'h0003);
      // disable freezes counting and releases both pins
      apb(1'b1, timer16_pkg::STATUS_ADDR, 8'h04);
      cyc(3);
      chk("oe_off", {14'h0000, compare_pin_one_oe, compare_pin_two_oe}, 16'h0000);
      rd_chk("timer_disable", timer16_pkg::STATUS_ADDR, 8'h07, 8'h04);
      apb(1'b0, timer16_pkg::CNT_LOW_ADDR, 8'h00);
      q0 = q;
      cyc(40);
      rd_chk("frozen", timer16_pkg::CNT_LOW_ADDR, 8'hFF, q0);
      apb(1'b1, timer16_pkg::STATUS_ADDR, 8'h00);
      // pwm: period by compare two, no compare flags, capture flag one per period
      apb(1'b1, timer16_pkg::CTRL_ONE_ADDR, 8'h01);
      apb(1'b1, timer16_pkg::CTRL_TWO_ADDR, 8'h94);
      apb(1'b1, timer16_pkg::CNT_LOW_ADDR, 8'h00);
      toggles = 0;
      prev = compare_pin_one;
      repeat (300) begin
         @(posedge pclk);
         if (compare_pin_one !== prev) toggles++;
         prev = compare_pin_one;
      end
      chk("pwm_edges", (toggles >= 4) ? 16'h0001 : 16'h0000, 16'h0001);
      rd_chk("pwm_flags", timer16_pkg::STATUS_ADDR, 8'hC8, 8'h80);
      // single pulse: falling edge on capture one starts it, compare one ends it
      apb(1'b1, timer16_pkg::CTRL_ONE_ADDR, 8'h04);
      apb(1'b1, timer16_pkg::CTRL_TWO_ADDR, 8'hA4);
      pins.drive(0, 1'b1, 6);
      pins.drive(0, 1'b0, 6);
      chk("pulse_on", {15'h0000, compare_pin_one}, 16'h0001);
      cyc(80);
      chk("pulse_off", {15'h0000, compare_pin_one}, 16'h0000);
      final_report();
   end
endmodule
`default_nettype wire
